//--- common/write_server_regs.svh
`ifndef WRITE_SERVER_REGS_SVH
`define WRITE_SERVER_REGS_SVH

// ==========================================
// Function and error codes
`define FC_SINGLE 8'h06
`define FC_MULTI 8'h10
`define EXC_FLAG 8'h80
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_FAIL 8'h04

// ==========================================
// Header field values and register count limits
`define PROTO_MODBUS 16'h0000
`define UNIT_ID 8'h00
`define LEN_SINGLE 16'h0006
`define LEN_RESP 8'h06
`define LEN_ERR 8'h03
`define LEN_MULTI_BASE 16'h0007
`define MULTI_MIN 16'h0001
`define MULTI_MAX 16'h007b

// ==========================================
// Frame byte positions and sizes
`define HDR_LAST 3'h6
`define IDX_FC 16'h0000
`define IDX_VAL_LO 16'h0004
`define IDX_BCOUNT 16'h0005
`define IDX_DATA 16'h0006
`define RESP_BYTES 4'hc
`define ERR_BYTES 4'h9

`endif

//--- common/write_server_pkg.sv
`default_nettype none

package write_server_pkg;

  typedef enum logic [1:0] {
    ST_HDR,
    ST_BODY,
    ST_WRITE,
    ST_RESP
  } parse_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } wr_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tx_beat_t;

endpackage

`default_nettype wire

//--- hw/modbus_write_server.sv
// Behaviour
// (RULE1) Function 06h writes exactly one 16-bit register and its request has length 0006h.
// (RULE2) A single write may target any address and value from 0000h to ffffh.
// (RULE3) A good single write is answered with length 0006h, function 06h and the same address and value.
// (RULE4) Function 10h writes one or more consecutive 16-bit registers.
// (RULE5) The client sends start address, count 0001h to 007bh, byte count twice the count, data and length 0007h+2N.
// (RULE6) A good multiple write is answered with length 0006h, function 10h, start address and count only.
// (RULE7) A failed write is answered with length 0003h, error code 86h or 90h and exception code 01 to 04.
// (RULE8) The first value lands at the start address and each next value at the next address.
// (RULE9) Every answer carries the transaction identifier of its request.
// (RULE10) The protocol identifier is zero in every frame.
// (RULE11) The unit identifier is always zero.
// (RULE12) Every multi-byte field travels most significant byte first.
// (RULE13) A bad register count or byte count draws an error frame instead of a normal answer.
// (RULE14) The error code is the received function code with its top bit set.

`include "write_server_regs.svh"
`default_nettype none

// ==========================================
// Receive FIFO
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_in;
  end

  // Flags are registered from the next count so full and empty never lag a cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready_out <= count_next != FULL_COUNT;
      out_valid_out <= count_next != '0;
    end
  end
endmodule

// ==========================================
// Write request interpreter
module modbus_write_server #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output write_server_pkg::wr_req_t wr_req_out,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  input wire logic wr_err_in,
  output write_server_pkg::tx_beat_t tx_beat_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in
);
  import write_server_pkg::*;

  parse_state_t state_reg;
  logic [2:0] hdr_idx_reg;
  logic [15:0] tid_reg;
  logic [15:0] proto_reg;
  logic [15:0] len_reg;
  logic [15:0] rem_reg;
  logic [15:0] body_idx_reg;
  logic [15:0] widx_reg;
  logic [15:0] addr_reg;
  logic [15:0] val_reg;
  logic [7:0] fc_reg;
  logic [7:0] hi_reg;
  logic [7:0] exc_reg;
  logic drop_reg;
  logic [3:0] tx_idx_reg;

  logic [7:0] fifo_data;
  logic fifo_valid;
  logic take;
  logic [7:0] fc_now;
  logic [7:0] exc_next;
  logic issue;
  wr_req_t wr_next;
  logic [3:0] tx_total;
  logic tx_adv;
  logic tx_done;

  // Bytes queue here while the storage stalls a write
  rx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(rx_byte_in),
    .in_valid_in(rx_valid_in),
    .in_ready_out(rx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(state_reg == ST_HDR || state_reg == ST_BODY)
  );

  assign take = fifo_valid && (state_reg == ST_HDR || state_reg == ST_BODY);

  // ==========================================
  // Body byte decode
  always_comb
  begin
    fc_now = (body_idx_reg == `IDX_FC) ? fifo_data : fc_reg;
    exc_next = exc_reg;
    issue = 1'b0;
    wr_next = wr_req_out;
    if (!drop_reg && exc_reg == `EXC_NONE)
    begin
      if (body_idx_reg == `IDX_FC && fifo_data != `FC_SINGLE && fifo_data != `FC_MULTI)
        exc_next = `EXC_FUNC;
      if (fc_now == `FC_SINGLE && body_idx_reg == `IDX_VAL_LO)
      begin
        if (len_reg != `LEN_SINGLE) // RULE1
          exc_next = `EXC_VALUE;
        else
        begin
          issue = 1'b1; // RULE2
          wr_next.addr = addr_reg;
          wr_next.data = {hi_reg, fifo_data}; // RULE12
        end
      end
      if (fc_now == `FC_MULTI && body_idx_reg == `IDX_BCOUNT)
      begin
        if (val_reg < `MULTI_MIN || val_reg > `MULTI_MAX || {8'h00, fifo_data} != {val_reg[14:0], 1'b0}
            || len_reg != `LEN_MULTI_BASE + {val_reg[14:0], 1'b0}) // RULE5
          exc_next = `EXC_VALUE; // RULE13
      end
      if (fc_now == `FC_MULTI && body_idx_reg >= `IDX_DATA && body_idx_reg[0])
      begin
        issue = 1'b1; // RULE4
        wr_next.addr = addr_reg + widx_reg; // RULE8
        wr_next.data = {hi_reg, fifo_data};
      end
      // A frame that ends after its function code but before its other fixed fields are complete is refused
      if (rem_reg == 16'h0001 && !issue && exc_next == `EXC_NONE
          && body_idx_reg < ((fc_now == `FC_SINGLE) ? `IDX_VAL_LO : `IDX_BCOUNT))
        exc_next = `EXC_VALUE; // RULE13
    end
  end

  // ==========================================
  // Frame parser
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ST_HDR;
      hdr_idx_reg <= 3'h0;
      tid_reg <= 16'h0000;
      proto_reg <= 16'h0000;
      len_reg <= 16'h0000;
      rem_reg <= 16'h0000;
      body_idx_reg <= 16'h0000;
      widx_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      val_reg <= 16'h0000;
      fc_reg <= 8'h00;
      hi_reg <= 8'h00;
      exc_reg <= `EXC_NONE;
      drop_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_HDR:
        begin
          if (take)
          begin
            hdr_idx_reg <= (hdr_idx_reg == `HDR_LAST) ? 3'h0 : hdr_idx_reg + 3'h1;
            unique case (hdr_idx_reg)
              3'h0: tid_reg[15:8] <= fifo_data; // RULE12
              3'h1: tid_reg[7:0] <= fifo_data;
              3'h2: proto_reg[15:8] <= fifo_data;
              3'h3: proto_reg[7:0] <= fifo_data;
              3'h4: len_reg[15:8] <= fifo_data;
              3'h5: len_reg[7:0] <= fifo_data;
              default:
              begin
                // Frames for another protocol or unit are swallowed without answer
                drop_reg <= proto_reg != `PROTO_MODBUS || fifo_data != `UNIT_ID; // RULE10 RULE11
                rem_reg <= len_reg - 16'h0001;
                body_idx_reg <= 16'h0000;
                widx_reg <= 16'h0000;
                exc_reg <= `EXC_NONE;
                if (len_reg > 16'h0001)
                  state_reg <= ST_BODY;
              end
            endcase
          end
        end
        ST_BODY:
        begin
          if (take)
          begin
            rem_reg <= rem_reg - 16'h0001;
            body_idx_reg <= body_idx_reg + 16'h0001;
            hi_reg <= fifo_data;
            exc_reg <= exc_next;
            unique case (body_idx_reg)
              16'h0000: fc_reg <= fifo_data;
              16'h0001: addr_reg[15:8] <= fifo_data;
              16'h0002: addr_reg[7:0] <= fifo_data;
              16'h0003: val_reg[15:8] <= fifo_data;
              16'h0004: val_reg[7:0] <= fifo_data;
              default: ;
            endcase
            if (issue)
            begin
              widx_reg <= widx_reg + 16'h0001;
              state_reg <= ST_WRITE;
            end
            else if (rem_reg == 16'h0001)
              state_reg <= drop_reg ? ST_HDR : ST_RESP;
          end
        end
        ST_WRITE:
        begin
          if (wr_ready_in)
          begin
            // Later words of a refused multiple write are consumed but not stored
            if (wr_err_in && exc_reg == `EXC_NONE)
              exc_reg <= `EXC_ADDR; // RULE7
            state_reg <= (rem_reg == 16'h0000) ? ST_RESP : ST_BODY;
          end
        end
        ST_RESP:
        begin
          if (tx_done)
            state_reg <= ST_HDR;
        end
      endcase
    end
  end

  // ==========================================
  // Storage write port
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_req_out <= '0;
      wr_valid_out <= 1'b0;
    end
    else if (state_reg == ST_BODY && take && issue)
    begin
      wr_req_out <= wr_next;
      wr_valid_out <= 1'b1;
    end
    else if (wr_ready_in)
      wr_valid_out <= 1'b0;
  end

  // ==========================================
  // Response builder
  function automatic logic [7:0] resp_byte(input logic [3:0] idx);
    logic err;
    err = exc_reg != `EXC_NONE;
    unique case (idx)
      4'h0: resp_byte = tid_reg[15:8]; // RULE9
      4'h1: resp_byte = tid_reg[7:0];
      4'h2: resp_byte = 8'(`PROTO_MODBUS >> 8); // RULE10
      4'h3: resp_byte = 8'h00;
      4'h4: resp_byte = 8'h00;
      4'h5: resp_byte = err ? `LEN_ERR : `LEN_RESP; // RULE3 RULE6 RULE7
      4'h6: resp_byte = `UNIT_ID; // RULE11
      4'h7: resp_byte = err ? (fc_reg | `EXC_FLAG) : fc_reg; // RULE14
      4'h8: resp_byte = err ? exc_reg : addr_reg[15:8]; // RULE12
      4'h9: resp_byte = addr_reg[7:0];
      4'ha: resp_byte = val_reg[15:8]; // RULE3 RULE6
      default: resp_byte = val_reg[7:0];
    endcase
  endfunction

  assign tx_total = (exc_reg != `EXC_NONE) ? `ERR_BYTES : `RESP_BYTES;
  assign tx_adv = state_reg == ST_RESP && (!tx_valid_out || tx_ready_in);
  assign tx_done = tx_adv && tx_idx_reg == tx_total;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_idx_reg <= 4'h0;
      tx_beat_out <= '0;
      tx_valid_out <= 1'b0;
    end
    else if (tx_adv)
    begin
      if (tx_done)
      begin
        tx_idx_reg <= 4'h0;
        tx_valid_out <= 1'b0;
      end
      else
      begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
        tx_beat_out.data <= resp_byte(tx_idx_reg);
        tx_beat_out.last <= tx_idx_reg == tx_total - 4'h1;
        tx_valid_out <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench/write_server_monitor.sv
`default_nettype none
// ==========
// Port checker
module write_server_monitor
  import write_server_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic rx_ready_out,
  input wire write_server_pkg::wr_req_t wr_req_out,
  input wire logic wr_valid_out,
  input wire logic wr_ready_in,
  input wire write_server_pkg::tx_beat_t tx_beat_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx_reg;
  logic [7:0] len_reg;
  wire logic [7:0] tx_data = tx_beat_out.data;

  // Byte position within the response frame
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      idx_reg <= 4'h0;
    else if (tx_valid_out && tx_ready_in)
      idx_reg <= tx_beat_out.last ? 4'h0 : idx_reg + 4'h1;

  // Length low byte tells normal from error frame
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      len_reg <= 8'h00;
    else if (tx_valid_out && tx_ready_in && idx_reg == 4'h5)
      len_reg <= tx_data;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_wr_req_hold: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_req_out))
    else $error("write request changed before acceptance");
  a_wr_one_shot: assert property (wr_valid_out && wr_ready_in |=> !wr_valid_out)
    else $error("write request repeated");
  a_tx_beat_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_beat_out))
    else $error("response byte changed before taken");
  a_hdr_zero: assert property (tx_valid_out && idx_reg inside {4'h2, 4'h3, 4'h4, 4'h6} |-> tx_data == 8'h00)
    else $error("protocol or unit byte not zero");
  a_len_value: assert property (tx_valid_out && idx_reg == 4'h5 |-> tx_data inside {8'h06, 8'h03})
    else $error("bad response length");
  a_frame_end: assert property (tx_valid_out && tx_beat_out.last |-> idx_reg == (len_reg == 8'h03 ? 4'h8 : 4'hb))
    else $error("response frame size wrong");
  a_resp_code: assert property (tx_valid_out && idx_reg == 4'h7 && len_reg == 8'h06 |-> tx_data inside {8'h06, 8'h10})
    else $error("normal response function code wrong");
  a_err_flag: assert property (tx_valid_out && idx_reg == 4'h7 && len_reg == 8'h03 |-> tx_data[7])
    else $error("error code top bit clear");
  a_exc_range: assert property (tx_valid_out && idx_reg == 4'h8 && len_reg == 8'h03 |-> tx_data inside {[8'h01:8'h04]})
    else $error("exception code out of range");

  c_fifo_full: cover property (!rx_ready_out);
  c_err_frame: cover property (tx_valid_out && idx_reg == 4'h8 && len_reg == 8'h03);
  c_multi_ok: cover property (tx_valid_out && idx_reg == 4'h7 && tx_data == 8'h10);
endmodule

bind modbus_write_server write_server_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon_u (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .rx_ready_out(rx_ready_out),
  .wr_req_out(wr_req_out),
  .wr_valid_out(wr_valid_out),
  .wr_ready_in(wr_ready_in),
  .tx_beat_out(tx_beat_out),
  .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in)
);
`default_nettype wire

//--- testbench/client_model.sv
`default_nettype none
// ==========
// Network client: byte source and response sink
module client_model (
  input wire logic ref_clk_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic took = 1'b0;
  int n = 0;

  initial
  begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  always @(posedge ref_clk_in)
    took <= rx_valid_out && rx_ready_in;

  // Byte held until taken; idle line toggles so stale data never looks valid
  always @(negedge ref_clk_in)
  begin
    n <= n + 1;
    tx_ready_out <= (n % 5) != 3;
    if (took || !rx_valid_out)
    begin
      if (q.size() > 0)
      begin
        rx_byte_out <= q.pop_front();
        rx_valid_out <= 1'b1;
      end
      else
      begin
        rx_byte_out <= ~rx_byte_out;
        rx_valid_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import write_server_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_ready_in = 1'b0;
  logic wr_err_in = 1'b0;
  logic err_mode = 1'b0;
  logic saw_full = 1'b0;
  logic [15:0] rnd = 16'h1962;
  logic [7:0] rx_byte;
  logic rx_valid, rx_ready, wr_valid, tx_valid, tx_ready;
  wr_req_t wr_req;
  tx_beat_t tx_beat;
  int hold_cnt = 0;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] exp_wr[$];
  logic [31:0] exp_tx[$];
  // Protocol id 0001h, then unit id 01h: both frames must be swallowed without answer
  logic [7:0] foreign[24] = '{8'h0b, 8'h01, 8'h00, 8'h01, 8'h00, 8'h06, 8'h00, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34,
    8'h0b, 8'h02, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34};

  always #5 ref_clk_in = ~ref_clk_in;

  modbus_write_server #(.FIFO_DEPTH(16)) dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .wr_req_out(wr_req),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready_in), .wr_err_in(wr_err_in), .tx_beat_out(tx_beat),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready));
  client_model client_u (.ref_clk_in(ref_clk_in), .rx_ready_in(rx_ready), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // ==========
  // Storage side: random stalls, long hold to fill the FIFO
  always @(negedge ref_clk_in)
  begin
    rnd <= lfsr(rnd);
    wr_ready_in <= (hold_cnt == 0) && rnd[0];
    wr_err_in <= err_mode;
    if (hold_cnt > 0)
      hold_cnt <= hold_cnt - 1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge ref_clk_in)
  begin
    if (rst_n_in && !rx_ready)
      saw_full <= 1'b1;
    if (wr_valid && wr_ready_in)
      check(wr_req, exp_wr.size() > 0 ? exp_wr.pop_front() : ~wr_req);
    if (tx_valid && tx_ready)
      check(32'(tx_beat), exp_tx.size() > 0 ? exp_tx.pop_front() : ~32'(tx_beat));
  end

  task send(input logic [15:0] tid, input logic [7:0] fc, input logic [7:0] body[$]);
    logic [15:0] len;
    len = 16'(body.size() + 2);
    body = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], 8'h00, fc, body};
    foreach (body[i])
      client_u.q.push_back(body[i]);
  endtask

  task resp(input logic [15:0] tid, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v,
    input logic [7:0] exc);
    logic [7:0] b[12];
    int n;
    n = exc != 8'h00 ? 9 : 12;
    b = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, n == 9 ? 8'h03 : 8'h06, 8'h00, fc,
      n == 9 ? exc : a[15:8], a[7:0], v[15:8], v[7:0]};
    for (int i = 0; i < n; i++)
      exp_tx.push_back({23'h0, b[i], i == n - 1});
  endtask

  task settle;
    int k;
    k = 0;
    while ((exp_tx.size() > 0 || exp_wr.size() > 0) && k < 3000)
    begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 3000)
      failures++;
    repeat (4) @(posedge ref_clk_in);
  endtask

  task single(input logic [15:0] tid, input logic [15:0] a, input logic [15:0] v, input logic [7:0] exc);
    exp_wr.push_back({a, v});
    resp(tid, exc != 8'h00 ? 8'h86 : 8'h06, a, v, exc);
    send(tid, 8'h06, '{a[15:8], a[7:0], v[15:8], v[7:0]});
    settle();
  endtask

  task multi(input logic [15:0] tid, input logic [15:0] a, input logic [15:0] n, input logic [7:0] bc,
    input int nd, input logic [7:0] exc);
    logic [7:0] body[$];
    logic [15:0] s;
    s = rnd;
    body = '{a[15:8], a[7:0], n[15:8], n[7:0], bc};
    for (int k = 0; k < nd; k++)
    begin
      s = lfsr(s);
      body.push_back(s[15:8]);
      body.push_back(s[7:0]);
      exp_wr.push_back({a + 16'(k), s});
    end
    resp(tid, exc != 8'h00 ? 8'h90 : 8'h10, a, n, exc);
    send(tid, 8'h10, body);
    settle();
  endtask

  task test_done;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    failures++;
    test_done();
  end

  initial
  begin
    repeat (20) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    single(16'h0001, rnd, ~rnd, 8'h00);
    single(16'hffff, 16'hffff, 16'h0000, 8'h00);
    hold_cnt = 80;
    multi(16'h1234, 16'hfffa, 16'd12, 8'd24, 12, 8'h00);
    multi(16'h0102, 16'h1770, 16'd1, 8'd2, 1, 8'h00);
    err_mode = 1'b1;
    single(16'h00aa, 16'h1770, 16'h0001, 8'h02);
    err_mode = 1'b0;
    multi(16'h0a01, 16'h0010, 16'h0000, 8'd0, 0, 8'h03);
    multi(16'h0a02, 16'h0010, 16'h007c, 8'd0, 0, 8'h03);
    multi(16'h0a03, 16'h0010, 16'h0001, 8'd0, 0, 8'h03);
    resp(16'h0a04, 8'h85, 16'h0000, 16'h0000, 8'h01);
    send(16'h0a04, 8'h05, '{8'h00, 8'h01, 8'h00, 8'h02});
    settle();
    // Single write with length 7, then one cut after the address high byte: both refused, nothing stored
    resp(16'h0a05, 8'h86, 16'h0000, 16'h0000, 8'h03);
    send(16'h0a05, 8'h06, '{8'h17, 8'h70, 8'h00, 8'h01, 8'h00});
    settle();
    resp(16'h0a06, 8'h86, 16'h0000, 16'h0000, 8'h03);
    send(16'h0a06, 8'h06, '{8'h17});
    settle();
    // An answer or write for a foreign frame would collide with the expectations of the next write
    foreach (foreign[i])
      client_u.q.push_back(foreign[i]);
    single(16'h0a07, 16'h1770, 16'h0001, 8'h00);
    check(32'(saw_full), 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
